/* File: verif/rtp_host.sv */
// host model: axi4-lite master reading and writing the block's registers
// assumes aclk from the bench; a stuck answer returns code 3
`timescale 1ns/1ns
`default_nettype none
module rtp_host
  import rtp_pkg::*;
(
  // clock
  input wire logic aclk,
  // write side
  output logic [ADDR_W-1:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read side
  output logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // ****************
  // bus cycles
  // ****************
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb, s_axi_araddr} = '0;
  end
  // released payload shows the inverse so a stale value cannot pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, b;
    b = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 60 && !b; i++) begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      b = s_axi_bvalid;
      if (b) r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (ta) s_axi_awaddr <= ~a;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tw) s_axi_wdata <= ~d;
      if (b) s_axi_bready <= 1'b0;
    end
  endtask
  // flags are read back here to learn which source fired
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, v;
    v = 1'b0;
    r = 2'h3;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 60 && !v; i++) begin
      @(negedge aclk);
      ta = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      if (v) r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (ta) s_axi_araddr <= ~a;
      if (v) s_axi_rready <= 1'b0;
    end
  endtask
endmodule // rtp_host
`default_nettype wire

/* File: verif/rtp_irq_props.sv */
// checker: bus handshakes and pin relations of the timer-pulse block
// assumes binding to rtp_irq_timer; sees only its ports
`timescale 1ns/1ns
`default_nettype none
module rtp_irq_props (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write side
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read side
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pins
  input wire logic int_n,
  input wire logic irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // properties
  // ****************
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_done;
    s_axi_bvalid && s_axi_bready;
  endsequence
  chk_reset_quiet: assert property (disable iff (1'b0)
    !aresetn |=> !s_axi_bvalid && !s_axi_rvalid) else $error("answer pending after reset");
  chk_write_answer: assert property (wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
    else $error("write answer late");
  chk_b_release: assert property (b_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer held");
  chk_busy_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  chk_pin_needs_irq: assert property (!int_n |-> irq)
    else $error("pin low without enabled flag");
  chk_flag_sticky: assert property ($fell(irq) |-> $rose(s_axi_bvalid))
    else $error("flag dropped without a write");
endmodule // rtp_irq_props

bind rtp_irq_timer rtp_irq_props u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .int_n(int_n), .irq(irq));
`default_nettype wire

/* File: verif/tb.sv */
// bench of the timer-pulse interrupt block: events, timer pulse, register bus
// assumes rtp_irq_timer, rtp_host and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("wrong value t=%0t got %h exp %h", $time, g, e); end end
module tb
  import rtp_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, int_n, clk_out, irq;
  rtp_evt_t evt = '0;
  int miscompares = 0;
  int n_tests = 0;
  // row: stamp bits, enables, event, flags, {int_n, irq}
  localparam logic [20:0] ROWS [9] = '{
    {2'h0, 6'h3f, 5'h10, 6'h02, 2'b01}, {2'h0, 6'h3f, 5'h08, 6'h04, 2'b01},
    {2'h0, 6'h3f, 5'h04, 6'h08, 2'b01}, {2'h0, 6'h3f, 5'h02, 6'h10, 2'b01},
    {2'h0, 6'h3f, 5'h01, 6'h20, 2'b01}, {2'h0, 6'h00, 5'h10, 6'h02, 2'b10},
    {2'h1, 6'h2f, 5'h02, 6'h18, 2'b01}, {2'h3, 6'h27, 5'h02, 6'h18, 2'b10},
    {2'h1, 6'h27, 5'h02, 6'h10, 2'b10}};

  // short release counts keep the run brief
  rtp_irq_timer #(.PRE_CYC(4), .REL_FAST(5), .REL_SLOW(20)) uut (.*);
  rtp_host host (.*);

  initial forever #5 aclk = ~aclk;

  task final_report;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic [1:0] r;
    host.wr(a, d, r);
    `CHK(r, e)
    if (r === 2'h3) final_report;
    // outputs are read at the falling edge, half a cycle after the edge that launches them
    @(negedge aclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    `CHK(r, er)
    `CHK(d, e)
    if (r === 2'h3) final_report;
    @(negedge aclk);
  endtask
  task pin(input logic v, input int n, output int c);
    c = 0;
    while (int_n !== v) begin
      if (c == n) begin
        miscompares++;
        final_report;
      end
      @(negedge aclk);
      c++;
    end
  endtask
  task pulse(input rtp_evt_t v);
    @(posedge aclk) evt <= v;
    @(posedge aclk) evt <= '0;
    @(negedge aclk);
  endtask

  initial begin
    int c, h;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK({int_n, irq}, 2'b10)
    rd(FLAGS_ADDR, 32'h0, RESP_OKAY);
    rd(IRQ_EN_ADDR, 32'h0, RESP_OKAY);
    rd(PINS_ADDR, 32'h1, RESP_OKAY);
    wr(8'h20, 32'h1, RESP_SLVERR);
    rd(8'h20, 32'h0, RESP_SLVERR);
    foreach (ROWS[i]) begin
      wr(CTRL_ADDR, {26'h0, ROWS[i][20:19], 4'h0}, RESP_OKAY);
      wr(IRQ_EN_ADDR, {26'h0, ROWS[i][18:13]}, RESP_OKAY);
      pulse(ROWS[i][12:8]);
      `CHK({int_n, irq}, ROWS[i][1:0])
      rd(FLAGS_ADDR, {26'h0, ROWS[i][7:2]}, RESP_OKAY);
      wr(FLAGS_ADDR, 32'h3f, RESP_OKAY);
      `CHK({int_n, irq}, 2'b10)
    end
    // single shot, fast release, pulse on clock pin
    wr(IRQ_EN_ADDR, 32'h1, RESP_OKAY);
    wr(PRESET_ADDR, 32'h2, RESP_OKAY);
    wr(CTRL_ADDR, 32'hc01, RESP_OKAY);
    pin(1'b0, 60, c);
    `CHK(clk_out, 1'b0)
    pin(1'b1, 20, c);
    `CHK(c >= 5 && c <= 6, 1'b1)
    rd(FLAGS_ADDR, 32'h1, RESP_OKAY);
    rd(CTRL_ADDR, 32'hc00, RESP_OKAY);
    repeat (40) @(negedge aclk);
    `CHK(int_n, 1'b1)
    // repeat mode: early release by flag clear and by enable clear
    wr(CTRL_ADDR, 32'hc03, RESP_OKAY);
    pin(1'b0, 60, c);
    wr(FLAGS_ADDR, 32'h1, RESP_OKAY);
    `CHK(int_n, 1'b1)
    pin(1'b0, 60, c);
    wr(IRQ_EN_ADDR, 32'h0, RESP_OKAY);
    `CHK(int_n, 1'b1)
    wr(FLAGS_ADDR, 32'h1, RESP_OKAY);
    repeat (12) @(negedge aclk);
    `CHK(int_n, 1'b1)
    rd(FLAGS_ADDR, 32'h1, RESP_OKAY);
    // slow source; stopping the timer leaves the pulse running
    wr(CTRL_ADDR, 32'hc06, RESP_OKAY);
    wr(PRESET_ADDR, 32'h1, RESP_OKAY);
    wr(IRQ_EN_ADDR, 32'h1, RESP_OKAY);
    wr(FLAGS_ADDR, 32'h3f, RESP_OKAY);
    wr(CTRL_ADDR, 32'hc07, RESP_OKAY);
    pin(1'b0, 600, c);
    wr(CTRL_ADDR, 32'hc06, RESP_OKAY);
    repeat (8) @(negedge aclk);
    `CHK(int_n, 1'b0)
    pin(1'b1, 20, c);
    `CHK(clk_out, 1'b1)
    // auto clock: square wave only while the pulse stands
    wr(FLAGS_ADDR, 32'h3f, RESP_OKAY);
    wr(CTRL_ADDR, 32'h0c6, RESP_OKAY);
    `CHK(clk_out, 1'b0)
    wr(CTRL_ADDR, 32'h0c7, RESP_OKAY);
    pin(1'b0, 600, c);
    h = 0;
    repeat (20) begin
      @(negedge aclk);
      if (clk_out) h++;
    end
    `CHK(h != 0, 1'b1)
    `CHK(clk_out, 1'b0)
    // later periods: 64 ticks of 4 cycles, less the 20 already waited
    pin(1'b0, 600, c);
    `CHK(c, 236)
    // static enable: a toggle every 4 cycles gives 8 high of 16 samples
    wr(CTRL_ADDR, 32'h100, RESP_OKAY);
    h = 0;
    repeat (16) begin
      @(negedge aclk);
      if (clk_out) h++;
    end
    `CHK(h, 8)
    final_report;
  end
endmodule // tb
`default_nettype wire

/* File: verilog/rtp_irq_timer.sv */
// interrupt output and countdown timer pulse logic with an AXI4-Lite register port
// assumes event inputs are one-cycle pulses synchronous to aclk
//
// Function
// - interrupt pin low when any of six gated source outputs is active
// - one readable sticky flag per source tells software which event came
// - source drives pin only when enabled; flags set regardless of enables, except the event flag under stamp select 1
// - switchover sets event flag when stamp select 1 and event or stamp enable
// - internal event interrupt from pin or switchover per stamp select, flag clear
// - countdown event sets timer flag and pulls interrupt pin low
// - timer pulse reaches pin only with countdown interrupt enable set
// - pulse self-releases after 122 us for select 00, else 7.813 ms
// - clearing timer flag releases the pulse at once
// - clearing countdown interrupt enable releases the pulse at once
// - stopping the timer leaves a running pulse to its own release time
// - timer flag stays set until software clears it
// - timer pulse enables clock output when both clock enables set, static clear
// - frequency select 110 puts the timer pulses on the clock output
// - countdown fires once in single mode, repeatedly in repeat mode
// - only the first period may deviate; later ones have fixed length
// - clock select picks 4096 Hz, 64 Hz, 1 Hz or 1/60 Hz source
// - single mode stops at zero and clears run; repeat reloads preset
`timescale 1ns/1ns
`default_nettype none

module rtp_irq_timer
  import rtp_pkg::*;
#(
  parameter int PRE_CYC = PRE_4096_CYC,
  parameter int REL_FAST = REL_FAST_CYC,
  parameter int REL_SLOW = REL_SLOW_CYC,
  parameter int TV_W = 12
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // source events
  input wire rtp_evt_t evt,
  // pins and interrupt
  output logic int_n,
  output logic clk_out,
  output logic irq
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    rtp_ctrl_t ctrl;
    logic [TV_W-1:0] preset;
    logic [TV_W-1:0] count;
    rtp_src_t flags;
    rtp_src_t en;
    logic pulse;
    logic [19:0] rel;
    logic [14:0] presc;
    logic [5:0] d64;
    logic [5:0] d1;
    logic [5:0] d60;
    logic sq;
    logic int_n;
    logic clk_out;
    logic irq;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } rtp_state_t;

  rtp_state_t s;
  rtp_state_t next_s;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic t4096, t64, t1, tmin, tick;
    logic fire, wr, clr_ok, rd_ok, run_hw;
    logic freq_ok, sq_tick, auto_clk, ev_int;
    logic [31:0] wv, rv;
    rtp_src_t set, clr;
    next_s = s;
    set = SRC_RST;
    clr = SRC_RST;
    t4096 = 1'b0;
    t64 = 1'b0;
    t1 = 1'b0;
    tmin = 1'b0;
    tick = 1'b0;
    fire = 1'b0;
    wr = 1'b0;
    run_hw = 1'b0;
    freq_ok = 1'b0;
    sq_tick = 1'b0;
    auto_clk = 1'b0;
    ev_int = 1'b0;
    rv = 32'h0;
    rd_ok = 1'b1;
    clr_ok = 1'b1;
    wv = 32'h0;

    // ****************************************
    // source clock enables
    // ****************************************
    // one chain so every rate stays phase locked
    t4096 = (s.presc == 15'(PRE_CYC - 1));
    t64 = t4096 && (s.d64 == 6'(DIV_64 - 1));
    t1 = t64 && (s.d1 == 6'(DIV_1 - 1));
    tmin = t1 && (s.d60 == 6'(DIV_MIN - 1));
    next_s.presc = t4096 ? 15'h0 : s.presc + 15'h1;
    if (t4096) begin
      next_s.d64 = t64 ? 6'h0 : s.d64 + 6'h1;
    end
    if (t64) begin
      next_s.d1 = t1 ? 6'h0 : s.d1 + 6'h1;
    end
    if (t1) begin
      next_s.d60 = tmin ? 6'h0 : s.d60 + 6'h1;
    end
    unique case (s.ctrl.timer_clk_sel)
      TD_4096: tick = t4096;
      TD_64: tick = t64;
      TD_1: tick = t1;
      2'h3: tick = tmin;
    endcase

    // ****************************************
    // countdown
    // ****************************************
    // the free-running prescaler makes only the first period uncertain
    if (s.ctrl.timer_run && tick) begin
      if (s.count <= TV_W'(1)) begin
        fire = (s.count == TV_W'(1));
        if (s.ctrl.repeat_sel && fire) begin
          next_s.count = s.preset;
        end else begin
          next_s.count = '0;
          next_s.ctrl.timer_run = 1'b0;
        end
      end else begin
        next_s.count = s.count - TV_W'(1);
      end
    end

    // ****************************************
    // source events
    // ****************************************
    // flags other than the event flag under stamp select 1 ignore the enables so software can poll
    set.timer = fire;
    set.update = evt.update;
    set.alarm = evt.alarm;
    set.switchover = evt.switchover;
    set.poweron = evt.poweron;
    ev_int = s.en.event_src && !s.flags.event_src &&
             (s.ctrl.stamp_source_sel ? evt.switchover : evt.event_input_pin);
    set.event_src = ev_int || (!s.ctrl.stamp_source_sel && evt.event_input_pin) ||
                    (s.ctrl.stamp_source_sel && evt.switchover &&
                     (s.en.event_src || s.ctrl.stamp_en));

    // ****************************************
    // pulse release counter
    // ****************************************
    if (s.pulse) begin
      if (s.rel == 20'h0) begin
        next_s.pulse = 1'b0;
      end else begin
        next_s.rel = s.rel - 20'h1;
      end
    end

    // run bit as the countdown leaves it, before any register write
    run_hw = next_s.ctrl.timer_run;

    // ****************************************
    // axi4-lite write
    // ****************************************
    if (s.awready && s_axi_awvalid) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s.wready && s_axi_wvalid) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    wr = s.aw_got && s.w_got && !s.bvalid;
    if (wr) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      unique case (s.awaddr)
        CTRL_ADDR: begin
          wv = merge(32'(s.ctrl), s.wdata, s.wstrb);
          next_s.ctrl = rtp_ctrl_t'(wv[11:0]);
          if (wv[0] && !s.ctrl.timer_run) begin
            next_s.count = s.preset;
          end else if (wv[0]) begin
            // a write landing on the firing tick must not revive single mode
            next_s.ctrl.timer_run = run_hw;
          end
          if (s.ctrl.timer_run && !wv[0]) begin
            next_s.ctrl.timer_run = 1'b0;
          end
        end
        PRESET_ADDR: begin
          wv = merge(32'(s.preset), s.wdata, s.wstrb);
          next_s.preset = wv[TV_W-1:0];
        end
        FLAGS_ADDR: clr = s.wstrb[0] ? rtp_src_t'(s.wdata[5:0]) : SRC_RST;
        IRQ_EN_ADDR: begin
          wv = merge(32'(s.en), s.wdata, s.wstrb);
          next_s.en = rtp_src_t'(wv[5:0]);
        end
        COUNT_ADDR, PINS_ADDR: clr_ok = 1'b1;
        default: clr_ok = 1'b0;
      endcase
      next_s.bresp = clr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;

    // ****************************************
    // flags
    // ****************************************
    // set wins over a clear in the same cycle
    next_s.flags = (s.flags & ~clr) | set;

    // ****************************************
    // timer pulse
    // ****************************************
    // early release on flag or enable clear
    if (fire) begin
      next_s.pulse = 1'b1;
      next_s.rel = (s.ctrl.timer_clk_sel == TD_4096) ? 20'(REL_FAST - 1)
                                                      : 20'(REL_SLOW - 1);
    end else if (clr.timer && s.flags.timer) begin
      next_s.pulse = 1'b0;
    end else if (!next_s.en.timer) begin
      next_s.pulse = 1'b0;
    end

    // ****************************************
    // axi4-lite read
    // ****************************************
    if (s.arready && s_axi_arvalid) begin
      unique case (s_axi_araddr)
        CTRL_ADDR: rv = 32'(s.ctrl);
        PRESET_ADDR: rv = 32'(s.preset);
        COUNT_ADDR: rv = 32'(s.count);
        FLAGS_ADDR: rv = 32'(s.flags);
        IRQ_EN_ADDR: rv = 32'(s.en);
        PINS_ADDR: rv = {29'h0, s.pulse, s.clk_out, s.int_n};
        default: rd_ok = 1'b0;
      endcase
      next_s.rvalid = 1'b1;
      next_s.rdata = rv;
      next_s.rresp = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.arready = !next_s.rvalid;

    // ****************************************
    // pins
    // ****************************************
    next_s.irq = |(next_s.flags & next_s.en);
    next_s.int_n = !((next_s.pulse && next_s.en.timer) ||
                     (next_s.flags.update && next_s.en.update) ||
                     (next_s.flags.alarm && next_s.en.alarm) ||
                     (next_s.flags.event_src && next_s.en.event_src) ||
                     (next_s.flags.switchover && next_s.en.switchover) ||
                     (next_s.flags.poweron && next_s.en.poweron));

    // ****************************************
    // clock output
    // ****************************************
    // square wave only for the three divider rates; other codes except 110 mean no clock
    freq_ok = (next_s.ctrl.clock_out_freq_sel <= 3'h2);
    unique case (next_s.ctrl.clock_out_freq_sel)
      3'h0: sq_tick = t4096;
      3'h1: sq_tick = t64;
      3'h2: sq_tick = t1;
      default: sq_tick = 1'b0;
    endcase
    if (sq_tick) begin
      next_s.sq = !s.sq;
    end
    auto_clk = next_s.pulse && next_s.en.timer && next_s.ctrl.clk_on_timer_en &&
               next_s.ctrl.clk_on_irq_en && !next_s.ctrl.clock_out_static_enable;
    if (next_s.ctrl.clock_out_freq_sel == FD_TIMER_PULSE) begin
      next_s.clk_out = !(next_s.pulse && next_s.en.timer);
    end else begin
      next_s.clk_out = freq_ok && next_s.sq &&
                       (next_s.ctrl.clock_out_static_enable || auto_clk);
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ctrl <= CTRL_RST;
      s.flags <= SRC_RST;
      s.en <= SRC_RST;
      s.int_n <= 1'b1;
      s.clk_out <= 1'b1;
      s.awready <= 1'b1;
      s.wready <= 1'b1;
      s.arready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = s.arready;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign int_n = s.int_n;
  assign clk_out = s.clk_out;
  assign irq = s.irq;

endmodule // rtp_irq_timer

`default_nettype wire

/* File: verilog/rtp_pkg.sv */
// package of the timer-pulse interrupt block: register map, field layouts, timing
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register port
`default_nettype none

package rtp_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] PRESET_ADDR = 8'h04;
  localparam logic [7:0] COUNT_ADDR = 8'h08;
  localparam logic [7:0] FLAGS_ADDR = 8'h0c;
  localparam logic [7:0] IRQ_EN_ADDR = 8'h10;
  localparam logic [7:0] PINS_ADDR = 8'h14;
  localparam int ADDR_W = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // field layouts
  // ****************************************
  typedef struct packed {
    logic [2:0] clock_out_freq_sel;
    logic clock_out_static_enable;
    logic clk_on_irq_en;
    logic clk_on_timer_en;
    logic stamp_en;
    logic stamp_source_sel;
    logic [1:0] timer_clk_sel;
    logic repeat_sel;
    logic timer_run;
  } rtp_ctrl_t;

  // same layout serves the flags and the enables
  typedef struct packed {
    logic poweron;
    logic switchover;
    logic event_src;
    logic alarm;
    logic update;
    logic timer;
  } rtp_src_t;

  typedef struct packed {
    logic update;
    logic alarm;
    logic event_input_pin;
    logic switchover;
    logic poweron;
  } rtp_evt_t;

  localparam rtp_ctrl_t CTRL_RST = 12'h000;
  localparam rtp_src_t SRC_RST = 6'h00;
  localparam logic [2:0] FD_TIMER_PULSE = 3'h6;
  localparam logic [1:0] TD_4096 = 2'h0;
  localparam logic [1:0] TD_64 = 2'h1;
  localparam logic [1:0] TD_1 = 2'h2;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_NS = 10;
  localparam int TICK_HZ = 4096;
  localparam int PRE_4096_CYC = CLK_HZ / TICK_HZ;
  localparam int DIV_64 = 64;
  localparam int DIV_1 = 64;
  localparam int DIV_MIN = 60;
  localparam int REL_FAST_NS = 122_000;
  localparam int REL_SLOW_NS = 7_813_000;
  localparam int REL_FAST_CYC = (REL_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int REL_SLOW_CYC = (REL_SLOW_NS + CLK_NS - 1) / CLK_NS;

endpackage

`default_nettype wire
